/* File: verif/dtsr_chk.sv */
// Port assertions for the converter register bank.
`timescale 1ns/1ps
`default_nettype none
module dtsr_chk
#(
   parameter MID_SCALE = 0
)
(
   input wire logic        clk,
   input wire logic        reset,
   input wire logic        wr_en,
   input wire logic        rd_en,
   input wire logic [3:0]  addr,
   input wire logic [15:0] wr_data,
   input wire logic        sync_mode,
   input wire logic        headroom_low,
   input wire logic [15:0] rd_data,
   input wire logic [15:0] active_code,
   input wire logic        ref_buf_off,
   input wire logic        alarm,
   input wire logic        load_strobe,
   input wire logic        soft_reset_pulse
);
   default clocking dc @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_load;
      wr_en && addr == 4'h5 && wr_data[4] && sync_mode && wr_data[3:0] != 4'hA;
   endsequence
   sequence s_key; wr_en && addr == 4'h5 && wr_data[3:0] == 4'hA; endsequence
   chk_load_fire: assert property (s_load |=> load_strobe)
      else $error("load strobe missing");
   chk_load_clear: assert property (load_strobe && !(wr_en && addr == 4'h5) |=> !load_strobe)
      else $error("load strobe stuck");
   chk_key_reset: assert property (s_key |=> soft_reset_pulse &&
      active_code == (MID_SCALE ? 16'h8000 : 16'h0000)) else $error("key reset failed");
   chk_key_clear: assert property (soft_reset_pulse && !(wr_en && addr == 4'h5)
      |=> !soft_reset_pulse) else $error("reset pulse stuck");
   chk_key_only: assert property (wr_en && addr == 4'h5 && wr_data[3:0] != 4'hA
      |=> !soft_reset_pulse) else $error("reset without key");
   chk_alarm_live: assert property (!reset |=> alarm == $past(headroom_low) || soft_reset_pulse)
      else $error("alarm does not follow headroom");
   chk_alarm_zero: assert property (alarm |-> active_code == 16'h0000 && ref_buf_off)
      else $error("output not zero in alarm");
   chk_status_rsvd: assert property (rd_en && addr == 4'h7 |=> rd_data[15:1] == 15'h0000)
      else $error("status reserved bits set");
   chk_status_bit: assert property (rd_en && addr == 4'h7 |=> rd_data[0] == $past(alarm))
      else $error("status bit wrong");
endmodule // dtsr_chk
bind dtsr_regs dtsr_chk #(.MID_SCALE(MID_SCALE)) u_chk
(
   .clk              (clk),
   .reset            (reset),
   .wr_en            (wr_en),
   .rd_en            (rd_en),
   .addr             (addr),
   .wr_data          (wr_data),
   .sync_mode        (sync_mode),
   .headroom_low     (headroom_low),
   .rd_data          (rd_data),
   .active_code      (active_code),
   .ref_buf_off      (ref_buf_off),
   .alarm            (alarm),
   .load_strobe      (load_strobe),
   .soft_reset_pulse (soft_reset_pulse)
);
`default_nettype wire

/* File: verif/dtsr_host.sv */
// Host model that issues register writes and reads.
`timescale 1ns/1ps
`default_nettype none
module dtsr_host
(
   input  wire logic        clk,
   output var  logic        wr_en,
   output var  logic        rd_en,
   output var  logic [3:0]  addr,
   output var  logic [15:0] wr_data,
   input  wire logic [15:0] rd_data
);
   initial {wr_en, rd_en, addr, wr_data} = '0;
   // Released data is inverted so stale values never look valid.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      #1 {wr_en, addr, wr_data} = {1'b1, a, d};
      @(posedge clk);
      #1 {wr_en, wr_data} = {1'b0, ~d};
   endtask
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge clk);
      #1 {rd_en, addr} = {1'b1, a};
      @(posedge clk);
      #1 rd_en = 1'b0;
      d = rd_data;
   endtask
endmodule // dtsr_host
`default_nettype wire

/* File: verif/dtsr_regs_tb.sv */
// Self-checking bench for the converter register bank.
`timescale 1ns/1ps
`default_nettype none
`include "dtsr_defines.vh"
module dtsr_regs_tb;
   logic        clk = 0, reset = 1, sync_mode = 0, ref_div = 0, headroom_low = 0;
   logic        wr_en, rd_en, rd_valid, ref_buf_off, alarm, load_strobe, soft_reset_pulse;
   logic [3:0]  addr;
   logic [15:0] wr_data, rd_data, active_code, d;
   logic [15:0] rd_data_z, active_code_z, rd_data_f, active_code_f;
   int          n_errors = 0, check_count = 0, cyc = 0;
   dtsr_regs #(.RESOLUTION(`DTSR_RES_12), .MID_SCALE(1)) DUT
   (
      .clk              (clk),
      .reset            (reset),
      .wr_en            (wr_en),
      .rd_en            (rd_en),
      .addr             (addr),
      .wr_data          (wr_data),
      .sync_mode        (sync_mode),
      .ref_div          (ref_div),
      .headroom_low     (headroom_low),
      .rd_data          (rd_data),
      .rd_valid         (rd_valid),
      .active_code      (active_code),
      .ref_buf_off      (ref_buf_off),
      .alarm            (alarm),
      .load_strobe      (load_strobe),
      .soft_reset_pulse (soft_reset_pulse)
   );
   // The zero-scale 14-bit and full variants see the same traffic and are compared alongside.
   dtsr_regs #(.RESOLUTION(`DTSR_RES_14), .MID_SCALE(0)) dut_zero
   (
      .clk              (clk),
      .reset            (reset),
      .wr_en            (wr_en),
      .rd_en            (rd_en),
      .addr             (addr),
      .wr_data          (wr_data),
      .sync_mode        (sync_mode),
      .ref_div          (ref_div),
      .headroom_low     (headroom_low),
      .rd_data          (rd_data_z),
      .rd_valid         (),
      .active_code      (active_code_z),
      .ref_buf_off      (),
      .alarm            (),
      .load_strobe      (),
      .soft_reset_pulse ()
   );
   dtsr_regs #(.RESOLUTION(`DTSR_RES_16), .MID_SCALE(0)) dut_full
   (
      .clk              (clk),
      .reset            (reset),
      .wr_en            (wr_en),
      .rd_en            (rd_en),
      .addr             (addr),
      .wr_data          (wr_data),
      .sync_mode        (sync_mode),
      .ref_div          (ref_div),
      .headroom_low     (headroom_low),
      .rd_data          (rd_data_f),
      .rd_valid         (),
      .active_code      (active_code_f),
      .ref_buf_off      (),
      .alarm            (),
      .load_strobe      (),
      .soft_reset_pulse ()
   );
   dtsr_host h
   (
      .clk     (clk),
      .wr_en   (wr_en),
      .rd_en   (rd_en),
      .addr    (addr),
      .wr_data (wr_data),
      .rd_data (rd_data)
   );
   initial forever #2.5 clk = ~clk;
   task finish_test;
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // A hang is cut short well past the roughly 55 cycles the tests need.
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_errors++;
         finish_test;
      end
   end
   task chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e)
      begin
         n_errors++;
         $display("MISMATCH %0t got %h exp %h", $time, g, e);
      end
   endtask
   task rc(input logic [3:0] a, input logic [15:0] e);
      h.rd(a, d);
      chk(d, e);
      chk({15'h0, rd_valid}, 16'h0001);
   endtask
   initial
   begin
      repeat (16) @(posedge clk);
      #1 {reset, sync_mode} = 2'b01;
      rc(4'h8, 16'h8000);
      chk(rd_data_z, 16'h0000);
      rc(4'h7, 16'h0000);
      h.wr(4'h8, 16'h1237);
      rc(4'h8, 16'h1230);
      chk(rd_data_z, 16'h1234);
      chk(rd_data_f, 16'h1237);
      chk(active_code, 16'h8000);
      h.wr(4'h5, 16'h0010);
      chk({15'h0, load_strobe}, 16'h0001);
      repeat (2) @(posedge clk);
      #1 chk(active_code, 16'h1230);
      chk(active_code_z, 16'h1234);
      chk({15'h0, load_strobe}, 16'h0000);
      rc(4'h5, 16'h0000);
      {headroom_low, ref_div} = 2'b11;
      repeat (2) @(posedge clk);
      #1 chk(active_code, 16'h0000);
      chk({15'h0, ref_buf_off}, 16'h0001);
      rc(4'h7, 16'h0001);
      rc(4'h8, 16'h1230);
      {headroom_low, ref_div} = 2'b00;
      repeat (2) @(posedge clk);
      #1 chk(active_code, 16'h1230);
      chk({15'h0, alarm}, 16'h0000);
      h.wr(4'h5, 16'h0005);
      chk({15'h0, soft_reset_pulse}, 16'h0000);
      rc(4'h8, 16'h1230);
      h.wr(4'h5, 16'h000A);
      chk({15'h0, soft_reset_pulse}, 16'h0001);
      rc(4'h8, 16'h8000);
      chk(rd_data_z, 16'h0000);
      chk({15'h0, soft_reset_pulse}, 16'h0000);
      rc(4'h5, 16'h0000);
      rc(4'hF, 16'h0000);
      sync_mode = 0;
      h.wr(4'h8, 16'hFFFF);
      repeat (2) @(posedge clk);
      #1 chk(active_code, 16'hFFF0);
      chk(active_code_z, 16'hFFFC);
      chk(active_code_f, 16'hFFFF);
      finish_test;
   end
endmodule // dtsr_regs_tb
`default_nettype wire

/* File: verilog/dtsr_code_mask.v */
// Resolution mask that forces the unused low code bits to zero.
`timescale 1ns/1ps
`default_nettype none
`include "dtsr_defines.vh"
module dtsr_code_mask
(
   input  wire [1:0]                 resolution,
   input  wire [`DTSR_DATA_W-1:0]    code_in,
   output reg  [`DTSR_DATA_W-1:0]    code_out
);
   always @*
   begin
      case (resolution)
         `DTSR_RES_14: code_out = code_in & `DTSR_MASK_14;
         `DTSR_RES_12: code_out = code_in & `DTSR_MASK_12;
         default:      code_out = code_in & `DTSR_MASK_16;
      endcase
   end
endmodule // dtsr_code_mask
`default_nettype wire

/* File: verilog/dtsr_defines.vh */
// Register offsets, field positions, reset values and variant codes for the converter register bank.
`ifndef DTSR_DEFINES_VH
`define DTSR_DEFINES_VH
`define DTSR_ADDR_W          4
`define DTSR_DATA_W          16
`define DTSR_OFF_ACTION      4'h5
`define DTSR_OFF_ALARM       4'h7
`define DTSR_OFF_CODE        4'h8
`define DTSR_LOAD_BIT        4
`define DTSR_SRST_HI         3
`define DTSR_SRST_LO         0
`define DTSR_SRST_KEY        4'hA
`define DTSR_ALARM_BIT       0
`define DTSR_ZERO16          16'h0000
`define DTSR_RST_ZERO_SCALE  16'h0000
`define DTSR_RST_MID_SCALE   16'h8000
`define DTSR_RES_16          2'h0
`define DTSR_RES_14          2'h1
`define DTSR_RES_12          2'h2
`define DTSR_MASK_16         16'hFFFF
`define DTSR_MASK_14         16'hFFFC
`define DTSR_MASK_12         16'hFFF0
`endif

/* File: verilog/dtsr_regs.v */
// Trigger, status and output code registers of a single-channel voltage-output converter.
// How it works
// - Load strobe in synchronous mode copies pending code to the active output.
// - Load strobe clears itself after one cycle; never needs rewriting to zero.
// - Key 1010 in soft reset field restores all registers to power-on defaults.
// - Soft reset field returns to zero by itself after any write.
// - Alarm flag reads 1 while headroom comparator reports low margin, else 0.
// - While alarmed, reference buffer is off and output is driven to zero.
// - Alarm keeps stored code; output resumes from it once the alarm clears.
// - Alarm is raised when reference halving leaves too little headroom.
// - Code register is 16-bit straight binary, MSB aligned; full variant uses all.
// - 14-bit variant uses bits 15 to 2; the two low bits read as zero.
// - 12-bit variant uses bits 15 to 4; the four low bits read as zero.
// - Code register resets to 0000h or 8000h by power-up variant.
// - Status register resets to zero; only bit zero carries the alarm.
`timescale 1ns/1ps
`default_nettype none
`include "dtsr_defines.vh"
module dtsr_regs
#(
   parameter [1:0] RESOLUTION = `DTSR_RES_16,
   parameter       MID_SCALE  = 0
)
(
   input  wire                       clk,
   input  wire                       reset,
   input  wire                       wr_en,
   input  wire                       rd_en,
   input  wire [`DTSR_ADDR_W-1:0]    addr,
   input  wire [`DTSR_DATA_W-1:0]    wr_data,
   input  wire                       sync_mode,
   input  wire                       ref_div,
   input  wire                       headroom_low,
   output reg  [`DTSR_DATA_W-1:0]    rd_data,
   output reg                        rd_valid,
   output reg  [`DTSR_DATA_W-1:0]    active_code,
   output reg                        ref_buf_off,
   output reg                        alarm,
   output reg                        load_strobe,
   output reg                        soft_reset_pulse
);
   localparam [`DTSR_DATA_W-1:0] CODE_RESET =
      (MID_SCALE != 0) ? `DTSR_RST_MID_SCALE : `DTSR_RST_ZERO_SCALE;

   reg  [`DTSR_DATA_W-1:0] code_q;
   reg  [`DTSR_DATA_W-1:0] code_d;
   reg  [`DTSR_DATA_W-1:0] held_q;
   reg  [`DTSR_DATA_W-1:0] held_d;
   reg  [`DTSR_DATA_W-1:0] active_d;
   reg  [`DTSR_DATA_W-1:0] rd_mux;
   reg  [`DTSR_DATA_W-1:0] rd_data_d;
   reg                     rd_valid_d;
   reg                     strobe_d;
   reg                     pulse_d;
   reg                     alarm_d;
   reg                     buf_off_d;
   wire [`DTSR_DATA_W-1:0] masked_wr;
   wire                    act_wr;
   wire                    code_wr;
   wire                    key_hit;
   wire                    load_req;
   wire                    alarm_now;

   // Low bits are stripped on entry, so readback and output agree.
   dtsr_code_mask u_mask
   (
      .resolution (RESOLUTION),
      .code_in    (wr_data),
      .code_out   (masked_wr)
   );

   assign act_wr    = wr_en && (addr == `DTSR_OFF_ACTION);
   assign code_wr   = wr_en && (addr == `DTSR_OFF_CODE);
   // Only the exact key acts; other patterns are dropped since the field stores nothing.
   assign key_hit   = act_wr &&
      (wr_data[`DTSR_SRST_HI:`DTSR_SRST_LO] == `DTSR_SRST_KEY);
   // A key in the same write wins, so the load bit is dropped with it.
   assign load_req  = act_wr && wr_data[`DTSR_LOAD_BIT] && sync_mode && !key_hit;
   // The comparator is analog; the halving setting is what provokes it.
   assign alarm_now = headroom_low;

   always @*
   begin
      code_d = code_q;
      if (key_hit)
      begin
         code_d = CODE_RESET;
      end
      else if (code_wr)
      begin
         code_d = masked_wr;
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         code_q <= CODE_RESET;
      end
      else
      begin
         code_q <= code_d;
      end
   end

   // Pending code moves to the output copy on the strobe, or at once without sync mode.
   always @*
   begin
      held_d = held_q;
      if (key_hit)
      begin
         held_d = CODE_RESET;
      end
      else if (load_strobe)
      begin
         held_d = code_q;
      end
      else if (!sync_mode)
      begin
         held_d = code_d;
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         held_q <= CODE_RESET;
      end
      else
      begin
         held_q <= held_d;
      end
   end

   // The strobe lives for one cycle only, so the host never writes it back to zero.
   always @*
   begin
      strobe_d = 1'b0;
      if (load_req)
      begin
         strobe_d = 1'b1;
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         load_strobe <= 1'b0;
      end
      else
      begin
         load_strobe <= strobe_d;
      end
   end

   // The reset pulse marks the key for one cycle; the field itself never holds it.
   always @*
   begin
      pulse_d = 1'b0;
      if (key_hit)
      begin
         pulse_d = 1'b1;
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         soft_reset_pulse <= 1'b0;
      end
      else
      begin
         soft_reset_pulse <= pulse_d;
      end
   end

   always @*
   begin
      alarm_d = alarm_now;
      if (key_hit)
      begin
         alarm_d = 1'b0;
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         alarm <= 1'b0;
      end
      else
      begin
         alarm <= alarm_d;
      end
   end

   always @*
   begin
      buf_off_d = alarm_now;
      if (key_hit)
      begin
         buf_off_d = 1'b0;
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         ref_buf_off <= 1'b0;
      end
      else
      begin
         ref_buf_off <= buf_off_d;
      end
   end

   always @*
   begin
      active_d = held_q;
      if (key_hit)
      begin
         active_d = CODE_RESET;
      end
      else if (alarm_now)
      begin
         active_d = `DTSR_ZERO16;
      end
      else if (load_strobe)
      begin
         active_d = code_q;
      end
      else
      begin
         // Stored code is never touched by the alarm, so output resumes from it.
         active_d = held_q;
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         active_code <= CODE_RESET;
      end
      else
      begin
         active_code <= active_d;
      end
   end

   always @*
   begin
      case (addr)
         `DTSR_OFF_ALARM:
         begin
            rd_mux = {{(`DTSR_DATA_W-1){1'b0}}, alarm};
         end
         `DTSR_OFF_CODE:
         begin
            rd_mux = code_q;
         end
         default:
         begin
            // Trigger fields are write-only and self clearing, so they read as zero.
            rd_mux = `DTSR_ZERO16;
         end
      endcase
   end

   // Read data holds until the next read or a key write clears it, so a slow host can still pick it up.
   always @*
   begin
      rd_data_d  = rd_data;
      rd_valid_d = 1'b0;
      if (key_hit)
      begin
         rd_data_d = `DTSR_ZERO16;
      end
      else if (rd_en)
      begin
         rd_data_d  = rd_mux;
         rd_valid_d = 1'b1;
      end
   end

   always @(posedge clk)
   begin
      if (reset)
      begin
         rd_data  <= `DTSR_ZERO16;
         rd_valid <= 1'b0;
      end
      else
      begin
         rd_data  <= rd_data_d;
         rd_valid <= rd_valid_d;
      end
   end
endmodule // dtsr_regs
`default_nettype wire
